// ### sfu_pkg.sv
package sfu_pkg;
    // Register byte addresses on the AXI4-Lite bus.
    localparam logic [7:0] ADDR_PSW_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_PWR_CTRL  = 8'h04;
    localparam logic [7:0] ADDR_ACC       = 8'h08;
    localparam logic [7:0] ADDR_OPERAND   = 8'h0C;
    localparam logic [7:0] ADDR_B_REG     = 8'h10;
    localparam logic [7:0] ADDR_OP_CMD    = 8'h14;
    localparam logic [7:0] ADDR_RESULT    = 8'h18;
    localparam logic [7:0] PWR_CTRL_INDEX = 8'h87;
    // Status word bit positions.
    localparam int BIT_CY = 7;
    localparam int BIT_AC = 6;
    localparam int BIT_OV = 2;
    localparam int BIT_F1 = 1;
    localparam int BIT_P  = 0;
    // Power control spare flag positions.
    localparam int BIT_GF1 = 3;
    localparam int BIT_GF0 = 2;
    localparam logic [7:0] PSW_RESET  = 8'h00;
    localparam logic [7:0] PWR_RESET  = 8'h00;
    localparam logic [7:0] PSW_SW_MSK = 8'hFE;
    localparam logic [7:0] PWR_SW_MSK = 8'h0C;
    localparam logic [15:0] MUL_MAX   = 16'h00FF;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Operation codes written to the command register.
    typedef enum logic [3:0] {
        OP_ADD   = 4'h0,
        OP_ADD_WITH_CARRY_OP  = 4'h1,
        OP_SUBTRACT_WITH_BORROW_OP  = 4'h2,
        OP_MUL   = 4'h3,
        OP_DIV   = 4'h4,
        OP_CLRC  = 4'h5,
        OP_SETC  = 4'h6,
        OP_CPLC  = 4'h7,
        OP_ANLC  = 4'h8,
        OP_ORLC  = 4'h9,
        OP_MOVC  = 4'hA,
        OP_RRC   = 4'hB,
        OP_RLC   = 4'hC,
        OP_DA    = 4'hD,
        OP_CJNE  = 4'hE,
        OP_NOP   = 4'hF
    } sfu_op_t;
endpackage : sfu_pkg

// ### sfu_alu.sv
`timescale 1ns/1ps
// Combinational flag and result calculation for one operation.
module sfu_alu (
    input  wire logic [3:0]  op,        // Operation code.
    input  wire logic [7:0]  acc,       // Accumulator operand.
    input  wire logic [7:0]  opnd,      // Second operand or bit source in bit 0.
    input  wire logic [7:0]  breg,      // Multiply and divide partner.
    input  wire logic        cy_in,     // Current carry.
    output logic      [15:0] result,    // Result, high byte for multiply and divide.
    output logic             cy_out,    // New carry.
    output logic             ov_out,    // New overflow.
    output logic             ac_out,    // New half carry.
    output logic             wr_cy,     // Carry is updated.
    output logic             wr_ovac,   // Overflow and half carry are updated.
    output logic             wr_ov      // Overflow alone is updated.
);
    logic [8:0]  sum9;
    logic [7:0]  low7;
    logic [4:0]  nib;
    logic [15:0] prod;
    logic        c6;
    logic        bsrc;
    logic        cin;
    always_comb begin
        bsrc    = opnd[0];
        cin     = (op == sfu_pkg::OP_ADD) ? 1'b0 : cy_in;
        sum9    = 9'h000;
        low7    = 8'h00;
        nib     = 5'h00;
        c6      = 1'b0;
        prod    = 16'h0000;
        result  = 16'h0000;
        cy_out  = cy_in;
        ov_out  = 1'b0;
        ac_out  = 1'b0;
        wr_cy   = 1'b1;
        wr_ovac = 1'b0;
        wr_ov   = 1'b0;
        case (op)
            sfu_pkg::OP_ADD, sfu_pkg::OP_ADD_WITH_CARRY_OP: begin
                sum9    = {1'b0, acc} + {1'b0, opnd} + {8'h00, cin};
                low7    = {1'b0, acc[6:0]} + {1'b0, opnd[6:0]} + {7'h00, cin};
                nib     = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
                c6      = low7[7];
                result  = {8'h00, sum9[7:0]};
                cy_out  = sum9[8];
                ov_out  = c6 ^ sum9[8];
                ac_out  = nib[4];
                wr_ovac = 1'b1;
            end
            sfu_pkg::OP_SUBTRACT_WITH_BORROW_OP: begin
                sum9    = {1'b0, acc} - {1'b0, opnd} - {8'h00, cy_in};
                low7    = {1'b0, acc[6:0]} - {1'b0, opnd[6:0]} - {7'h00, cy_in};
                nib     = {1'b0, acc[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cy_in};
                c6      = low7[7];
                result  = {8'h00, sum9[7:0]};
                cy_out  = sum9[8];
                ov_out  = c6 ^ sum9[8];
                ac_out  = nib[4];
                wr_ovac = 1'b1;
            end
            sfu_pkg::OP_MUL: begin
                prod   = {8'h00, acc} * {8'h00, breg};
                result = prod;
                cy_out = 1'b0;
                ov_out = prod > sfu_pkg::MUL_MAX;
                wr_ov  = 1'b1;
            end
            sfu_pkg::OP_DIV: begin
                cy_out = 1'b0;
                wr_ov  = 1'b1;
                if (breg == 8'h00) begin
                    ov_out = 1'b1;
                    result = 16'hFFFF;
                end else begin
                    result = {acc % breg, acc / breg};
                end
            end
            sfu_pkg::OP_CLRC: cy_out = 1'b0;
            sfu_pkg::OP_SETC: cy_out = 1'b1;
            sfu_pkg::OP_CPLC: cy_out = ~cy_in;
            sfu_pkg::OP_ANLC: cy_out = cy_in & bsrc;
            sfu_pkg::OP_ORLC: cy_out = cy_in | bsrc;
            sfu_pkg::OP_MOVC: cy_out = bsrc;
            sfu_pkg::OP_RRC: begin
                result = {8'h00, cy_in, acc[7:1]};
                cy_out = acc[0];
            end
            sfu_pkg::OP_RLC: begin
                result = {8'h00, acc[6:0], cy_in};
                cy_out = acc[7];
            end
            sfu_pkg::OP_DA: begin
                sum9 = {1'b0, acc};
                if (acc[3:0] > 4'h9 || breg[0]) begin
                    sum9 = sum9 + 9'h006;
                end
                if (sum9[7:4] > 4'h9 || sum9[8] || cy_in) begin
                    sum9 = sum9 + 9'h060;
                end
                result = {8'h00, sum9[7:0]};
                cy_out = cy_in | sum9[8];
            end
            sfu_pkg::OP_CJNE: begin
                result = {8'h00, acc};
                cy_out = acc < opnd;
            end
            default: wr_cy = 1'b0;
        endcase
    end
endmodule : sfu_alu

// ### sfu_flags.sv
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module sfu_flags (
    input  wire logic        aclk,          // Core clock, 40 MHz.
    input  wire logic        aresetn,       // Synchronous reset, active low.
    input  wire logic [7:0]  s_axi_awaddr,  // Write address.
    input  wire logic        s_axi_awvalid, // Write address valid.
    output logic             s_axi_awready, // Write address ready.
    input  wire logic [31:0] s_axi_wdata,   // Write data.
    input  wire logic [3:0]  s_axi_wstrb,   // Write strobes.
    input  wire logic        s_axi_wvalid,  // Write data valid.
    output logic             s_axi_wready,  // Write data ready.
    output logic [1:0]       s_axi_bresp,   // Write response.
    output logic             s_axi_bvalid,  // Write response valid.
    input  wire logic        s_axi_bready,  // Write response ready.
    input  wire logic [7:0]  s_axi_araddr,  // Read address.
    input  wire logic        s_axi_arvalid, // Read address valid.
    output logic             s_axi_arready, // Read address ready.
    output logic [31:0]      s_axi_rdata,   // Read data.
    output logic [1:0]       s_axi_rresp,   // Read response.
    output logic             s_axi_rvalid,  // Read data valid.
    input  wire logic        s_axi_rready   // Read data ready.
);
    logic [7:0]  psw_reg;
    logic [7:0]  pwr_reg;
    logic [7:0]  acc_reg;
    logic [7:0]  opnd_reg;
    logic [7:0]  b_reg;
    logic [3:0]  op_reg;
    logic        go_reg;
    logic [15:0] res_reg;
    logic [7:0]  aw_reg;
    logic        aw_full_reg;
    logic [31:0] wd_reg;
    logic [3:0]  ws_reg;
    logic        w_full_reg;
    logic [15:0] alu_res;
    logic        alu_cy;
    logic        alu_ov;
    logic        alu_ac;
    logic        alu_wr_cy;
    logic        alu_wr_ovac;
    logic        alu_wr_ov;
    logic        wr_fire;
    logic        rd_fire;
    logic        wr_ok;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == sfu_pkg::ADDR_PSW_FLAGS) || (a == sfu_pkg::ADDR_PWR_CTRL)
                  || (a == sfu_pkg::ADDR_ACC) || (a == sfu_pkg::ADDR_OPERAND)
                  || (a == sfu_pkg::ADDR_B_REG) || (a == sfu_pkg::ADDR_OP_CMD)
                  || (a == sfu_pkg::ADDR_RESULT);
    endfunction : addr_known

    sfu_alu u_alu (
        .op      (op_reg),
        .acc     (acc_reg),
        .opnd    (opnd_reg),
        .breg    (b_reg),
        .cy_in   (psw_reg[sfu_pkg::BIT_CY]),
        .result  (alu_res),
        .cy_out  (alu_cy),
        .ov_out  (alu_ov),
        .ac_out  (alu_ac),
        .wr_cy   (alu_wr_cy),
        .wr_ovac (alu_wr_ovac),
        .wr_ov   (alu_wr_ov)
    );

    // Write address and data are caught in either order; response follows both.
    assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign wr_ok   = addr_known(aw_reg) && ws_reg[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg   <= 1'b0;
            aw_reg        <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_full_reg && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg   <= 1'b1;
                aw_reg        <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wr_fire) begin
                aw_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg   <= 1'b0;
            wd_reg       <= 32'h0000_0000;
            ws_reg       <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_full_reg && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg   <= 1'b1;
                wd_reg       <= s_axi_wdata;
                ws_reg       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_fire) begin
                w_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= sfu_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_known(aw_reg) ? sfu_pkg::RESP_OKAY : sfu_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Operand registers and command launch; an operation runs the cycle after go.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_reg  <= 8'h00;
            opnd_reg <= 8'h00;
            b_reg    <= 8'h00;
            op_reg   <= sfu_pkg::OP_NOP;
            go_reg   <= 1'b0;
            res_reg  <= 16'h0000;
        end else begin
            go_reg <= 1'b0;
            if (go_reg) begin
                res_reg <= alu_res;
                if (op_reg == sfu_pkg::OP_MUL || op_reg == sfu_pkg::OP_DIV) begin
                    acc_reg <= alu_res[7:0];
                    b_reg   <= alu_res[15:8];
                end else if (op_reg != sfu_pkg::OP_CJNE && op_reg != sfu_pkg::OP_NOP
                             && (alu_wr_ovac || op_reg == sfu_pkg::OP_RRC
                             || op_reg == sfu_pkg::OP_RLC || op_reg == sfu_pkg::OP_DA)) begin
                    acc_reg <= alu_res[7:0];
                end
            end
            if (wr_fire && wr_ok) begin
                case (aw_reg)
                    sfu_pkg::ADDR_ACC:     acc_reg  <= wd_reg[7:0];
                    sfu_pkg::ADDR_OPERAND: opnd_reg <= wd_reg[7:0];
                    sfu_pkg::ADDR_B_REG:   b_reg    <= wd_reg[7:0];
                    sfu_pkg::ADDR_OP_CMD: begin
                        op_reg <= wd_reg[3:0];
                        go_reg <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Status word: hardware updates win over a software write in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psw_reg <= sfu_pkg::PSW_RESET;
        end else begin
            if (wr_fire && wr_ok && aw_reg == sfu_pkg::ADDR_PSW_FLAGS) begin
                psw_reg[7:1] <= wd_reg[7:1];
            end
            if (go_reg && alu_wr_cy) begin
                psw_reg[sfu_pkg::BIT_CY] <= alu_cy;
            end
            if (go_reg && (alu_wr_ovac || alu_wr_ov)) begin
                psw_reg[sfu_pkg::BIT_OV] <= alu_ov;
            end
            if (go_reg && alu_wr_ovac) begin
                psw_reg[sfu_pkg::BIT_AC] <= alu_ac;
            end
            psw_reg[sfu_pkg::BIT_P] <= ^((go_reg && (op_reg == sfu_pkg::OP_MUL
                || op_reg == sfu_pkg::OP_DIV || alu_wr_ovac || op_reg == sfu_pkg::OP_RRC
                || op_reg == sfu_pkg::OP_RLC || op_reg == sfu_pkg::OP_DA))
                ? alu_res[7:0]
                : ((wr_fire && wr_ok && aw_reg == sfu_pkg::ADDR_ACC) ? wd_reg[7:0]
                : acc_reg));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_reg <= sfu_pkg::PWR_RESET;
        end else if (wr_fire && wr_ok && aw_reg == sfu_pkg::ADDR_PWR_CTRL) begin
            pwr_reg <= wd_reg[7:0] & sfu_pkg::PWR_SW_MSK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= sfu_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (rd_fire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= addr_known(s_axi_araddr) ? sfu_pkg::RESP_OKAY
                                                          : sfu_pkg::RESP_SLVERR;
                case (s_axi_araddr)
                    sfu_pkg::ADDR_PSW_FLAGS: s_axi_rdata <= {24'h000000, psw_reg};
                    sfu_pkg::ADDR_PWR_CTRL:  s_axi_rdata <= {24'h000000, pwr_reg};
                    sfu_pkg::ADDR_ACC:       s_axi_rdata <= {24'h000000, acc_reg};
                    sfu_pkg::ADDR_OPERAND:   s_axi_rdata <= {24'h000000, opnd_reg};
                    sfu_pkg::ADDR_B_REG:     s_axi_rdata <= {24'h000000, b_reg};
                    sfu_pkg::ADDR_OP_CMD:    s_axi_rdata <= {28'h0000000, op_reg};
                    sfu_pkg::ADDR_RESULT:    s_axi_rdata <= {16'h0000, res_reg};
                    default:                 s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    AST_PARITY: assert property (@(posedge aclk) disable iff (!aresetn)
        !go_reg ##1 !go_reg |-> psw_reg[sfu_pkg::BIT_P] == ^acc_reg)
        else $error("parity flag does not match accumulator");
    AST_ADD_OV: assert property (@(posedge aclk) disable iff (!aresetn)
        go_reg && op_reg == sfu_pkg::OP_ADD |=> psw_reg[sfu_pkg::BIT_OV] ==
        (($past(acc_reg[7]) == $past(opnd_reg[7])) && ($past(acc_reg[7]) != acc_reg[7])))
        else $error("add overflow wrong");
    AST_SUBTRACT_WITH_BORROW_OP_OV: assert property (@(posedge aclk) disable iff (!aresetn)
        go_reg && op_reg == sfu_pkg::OP_SUBTRACT_WITH_BORROW_OP |=> psw_reg[sfu_pkg::BIT_OV] ==
        (($past(acc_reg[7]) != $past(opnd_reg[7])) && ($past(acc_reg[7]) != acc_reg[7])))
        else $error("subtract overflow wrong");
    AST_MUL: assert property (@(posedge aclk) disable iff (!aresetn)
        go_reg && op_reg == sfu_pkg::OP_MUL |=> !psw_reg[sfu_pkg::BIT_CY]
        && psw_reg[sfu_pkg::BIT_OV] == (b_reg != 8'h00))
        else $error("multiply flags wrong");
    AST_DIV: assert property (@(posedge aclk) disable iff (!aresetn)
        go_reg && op_reg == sfu_pkg::OP_DIV |=> !psw_reg[sfu_pkg::BIT_CY]
        && psw_reg[sfu_pkg::BIT_OV] == ($past(b_reg) == 8'h00))
        else $error("divide flags wrong");
    AST_SETC: assert property (@(posedge aclk) disable iff (!aresetn)
        go_reg && op_reg == sfu_pkg::OP_SETC |=> psw_reg[sfu_pkg::BIT_CY]
        && $stable(psw_reg[sfu_pkg::BIT_OV]) && $stable(psw_reg[sfu_pkg::BIT_AC]))
        else $error("set carry wrong");
    AST_USER_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
        !(wr_fire && aw_reg == sfu_pkg::ADDR_PSW_FLAGS) |=> $stable(psw_reg[sfu_pkg::BIT_F1]))
        else $error("user flag changed without a write");
    AST_SPARE: assert property (@(posedge aclk) disable iff (!aresetn)
        (pwr_reg & ~sfu_pkg::PWR_SW_MSK) == 8'h00)
        else $error("power control holds stray bits");
    AST_BRESP: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire |=> s_axi_bvalid)
        else $error("write response missing");
    COV_DIV0: cover property (@(posedge aclk) go_reg && op_reg == sfu_pkg::OP_DIV
        && b_reg == 8'h00);
    COV_ADDOV: cover property (@(posedge aclk) go_reg && op_reg == sfu_pkg::OP_ADD && alu_ov);
    COV_MULOV: cover property (@(posedge aclk) go_reg && op_reg == sfu_pkg::OP_MUL && alu_ov);
endmodule : sfu_flags

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        aclk;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    int          failures;
    int          comparisons;
    int          cycles;
    localparam int LIMIT = 20000;

    sfu_flags sfu_flags_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );

    always #12.5 aclk = ~aclk;

    task automatic results();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // A hung handshake ends the run here as a mismatch.
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        logic aw_d = 1'b0;
        logic w_d = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge aclk);
            if (!aw_d && s_axi_awready === 1'b1) begin
                aw_d = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_d && s_axi_wready === 1'b1) begin
                w_d = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        axi_wr(a, {24'h0, d}, 4'hF, r);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        check(d, exp, what);
        check({30'h0, r}, {30'h0, sfu_pkg::RESP_OKAY}, "read response");
    endtask : rd_chk

    // Loads operands and the status word, launches one operation, then reads the status word.
    task automatic run_op(input logic [3:0] op, input logic [7:0] a, input logic [7:0] o,
                          input logic [7:0] b, input logic [7:0] pre, input logic [7:0] exp,
                          input logic [7:0] msk);
        logic [31:0] d;
        logic [1:0]  r;
        wr(sfu_pkg::ADDR_ACC, a);
        wr(sfu_pkg::ADDR_OPERAND, o);
        wr(sfu_pkg::ADDR_B_REG, b);
        wr(sfu_pkg::ADDR_PSW_FLAGS, pre);
        wr(sfu_pkg::ADDR_OP_CMD, {4'h0, op});
        repeat (3) @(posedge aclk);
        axi_rd(sfu_pkg::ADDR_PSW_FLAGS, d, r);
        check(d & {24'h0, msk}, {24'h0, exp & msk}, "status after op");
    endtask : run_op

    task automatic t_add();
        run_op(sfu_pkg::OP_ADD, 8'h7F, 8'h01, 8'h00, 8'h00, 8'h45, 8'hFF);
        run_op(sfu_pkg::OP_ADD, 8'h80, 8'h80, 8'h00, 8'h00, 8'h84, 8'hFF);
        run_op(sfu_pkg::OP_ADD, 8'h01, 8'h01, 8'h00, 8'h04, 8'h01, 8'hFF);
        run_op(sfu_pkg::OP_ADD_WITH_CARRY_OP, 8'h7E, 8'h01, 8'h00, 8'h80, 8'h45, 8'hFF);
    endtask : t_add

    task automatic t_sub();
        run_op(sfu_pkg::OP_SUBTRACT_WITH_BORROW_OP, 8'h80, 8'h01, 8'h00, 8'h00, 8'h45, 8'hFF);
        run_op(sfu_pkg::OP_SUBTRACT_WITH_BORROW_OP, 8'h00, 8'h00, 8'h00, 8'h80, 8'hC0, 8'hFF);
        run_op(sfu_pkg::OP_SUBTRACT_WITH_BORROW_OP, 8'h05, 8'h03, 8'h00, 8'h04, 8'h01, 8'hFF);
    endtask : t_sub

    task automatic t_mul_div();
        run_op(sfu_pkg::OP_MUL, 8'h10, 8'h00, 8'h10, 8'h80, 8'h04, 8'hFF);
        rd_chk(sfu_pkg::ADDR_RESULT, 32'h0000_0100, "product");
        run_op(sfu_pkg::OP_MUL, 8'h11, 8'h00, 8'h0F, 8'h84, 8'h00, 8'hFF);
        rd_chk(sfu_pkg::ADDR_RESULT, 32'h0000_00FF, "product");
        run_op(sfu_pkg::OP_DIV, 8'h64, 8'h00, 8'h00, 8'h80, 8'h04, 8'hFE);
        run_op(sfu_pkg::OP_DIV, 8'h65, 8'h00, 8'h0A, 8'h84, 8'h00, 8'hFF);
        rd_chk(sfu_pkg::ADDR_RESULT, 32'h0000_010A, "quotient");
    endtask : t_mul_div

    // Carry-only operations must leave overflow and half carry as they were.
    task automatic t_carry_ops();
        run_op(sfu_pkg::OP_CLRC, 8'h00, 8'h00, 8'h00, 8'hC4, 8'h44, 8'hFF);
        run_op(sfu_pkg::OP_SETC, 8'h01, 8'h00, 8'h00, 8'h44, 8'hC5, 8'hFF);
        run_op(sfu_pkg::OP_CPLC, 8'h00, 8'h00, 8'h00, 8'hC4, 8'h44, 8'hFF);
        run_op(sfu_pkg::OP_ANLC, 8'h00, 8'h00, 8'h00, 8'hC4, 8'h44, 8'hFF);
        run_op(sfu_pkg::OP_ORLC, 8'h00, 8'h01, 8'h00, 8'h44, 8'hC4, 8'hFF);
        run_op(sfu_pkg::OP_MOVC, 8'h00, 8'h01, 8'h00, 8'h44, 8'hC4, 8'hFF);
        run_op(sfu_pkg::OP_RRC, 8'h01, 8'h00, 8'h00, 8'h44, 8'hC4, 8'hFF);
        run_op(sfu_pkg::OP_RLC, 8'h80, 8'h00, 8'h00, 8'h44, 8'hC4, 8'hFF);
        run_op(sfu_pkg::OP_DA, 8'h9A, 8'h00, 8'h00, 8'h44, 8'hC4, 8'hFF);
        run_op(sfu_pkg::OP_CJNE, 8'h01, 8'h02, 8'h00, 8'h44, 8'hC5, 8'hFF);
        run_op(sfu_pkg::OP_NOP, 8'h00, 8'h00, 8'h00, 8'hC4, 8'hC4, 8'hFF);
    endtask : t_carry_ops

    task automatic t_parity();
        logic [7:0] v [7] = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hFF, 8'h7F, 8'hA5};
        logic [31:0] d;
        logic [1:0]  r;
        foreach (v[i]) begin
            wr(sfu_pkg::ADDR_ACC, v[i]);
            repeat (2) @(posedge aclk);
            axi_rd(sfu_pkg::ADDR_PSW_FLAGS, d, r);
            check({31'h0, d[0]}, {31'h0, ^v[i]}, "parity");
        end
    endtask : t_parity

    task automatic t_soft_flags();
        logic [1:0] r;
        rd_chk(sfu_pkg::ADDR_PSW_FLAGS, 32'h0, "status reset");
        rd_chk(sfu_pkg::ADDR_PWR_CTRL, 32'h0, "power reset");
        wr(sfu_pkg::ADDR_PSW_FLAGS, 8'h3A);
        rd_chk(sfu_pkg::ADDR_PSW_FLAGS, 32'h3A, "user flags");
        run_op(sfu_pkg::OP_ADD, 8'h01, 8'h01, 8'h00, 8'h3A, 8'h3B, 8'hFF);
        axi_wr(sfu_pkg::ADDR_PSW_FLAGS, 32'h0, 4'h0, r);
        rd_chk(sfu_pkg::ADDR_PSW_FLAGS, 32'h3B, "no lane write");
        wr(sfu_pkg::ADDR_PWR_CTRL, 8'hFF);
        rd_chk(sfu_pkg::ADDR_PWR_CTRL, 32'h0C, "spare flags");
        wr(sfu_pkg::ADDR_PWR_CTRL, 8'h08);
        rd_chk(sfu_pkg::ADDR_PWR_CTRL, 32'h08, "spare high");
        wr(sfu_pkg::ADDR_PWR_CTRL, 8'h04);
        rd_chk(sfu_pkg::ADDR_PWR_CTRL, 32'h04, "spare low");
        rd_chk(sfu_pkg::ADDR_PSW_FLAGS, 32'h3B, "status kept");
    endtask : t_soft_flags

    task automatic t_bus_errors();
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(8'h1C, 32'hFF, 4'hF, r);
        check({30'h0, r}, {30'h0, sfu_pkg::RESP_SLVERR}, "unmapped write");
        axi_rd(8'h1C, d, r);
        check({30'h0, r}, {30'h0, sfu_pkg::RESP_SLVERR}, "unmapped read");
        check(d, 32'h0, "unmapped data");
        rd_chk(sfu_pkg::ADDR_PWR_CTRL, 32'h04, "power kept");
    endtask : t_bus_errors

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        failures = 0;
        comparisons = 0;
        cycles = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_soft_flags();
        t_add();
        t_sub();
        t_mul_div();
        t_carry_ops();
        t_parity();
        t_bus_errors();
        results();
    end
endmodule : tb_top
